// ### core/udsec_pkg.sv
// constants and types for the usb status and control endpoint block
`default_nettype none
package udsec_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ       = 50;
  localparam int RESUME_MIN_US = 3000;
  localparam int IDLE_US       = 3000;
  // forced resume must last longer than the minimum, so one cycle more
  localparam int RESUME_CYCLES = RESUME_MIN_US * CLK_MHZ + 1;
  localparam int IDLE_CYCLES   = IDLE_US * CLK_MHZ;
  localparam int CNT_W         = 18;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h1;
  localparam logic [3:0] ADDR_MASK     = 4'h2;
  localparam logic [3:0] ADDR_EP0CSR   = 4'h3;
  localparam logic [3:0] ADDR_EP0SIZE  = 4'h4;
  localparam logic [3:0] ADDR_CONFIG   = 4'h5;
  localparam int         ADDR_BUF_BIT  = 3;

  localparam int CTRL_ENABLE   = 0;
  localparam int CTRL_CLK_GATE = 1;
  localparam int CTRL_RESUME   = 2;
  localparam int CTRL_DONE_IE  = 3;
  localparam logic [7:0] CTRL_RW_BITS = 8'h0b;

  localparam int ST_CONFIG  = 0;
  localparam int ST_SETUP   = 1;
  localparam int ST_SOF     = 2;
  localparam int ST_CFG_CHG = 3;
  localparam int ST_BUS_RST = 4;
  localparam int ST_WAKEUP  = 5;
  localparam int ST_SUSPEND = 6;
  localparam logic [7:0] ST_FLAG_BITS = 8'h7e;

  localparam int MSK_STALL = 0;
  localparam logic [7:0] MSK_RW_BITS = 8'h7e;

  localparam int CSR_TX_ARMED = 0;
  localparam int CSR_TX_DONE  = 1;
  localparam int CSR_RX_FULL  = 2;
  localparam int CSR_RX_DONE  = 3;

  localparam int CFG_RST_TO_IRQ = 0;
  localparam int SIZE_TX_LSB    = 4;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    RESP_NONE  = 3'h0,
    RESP_ACK   = 3'h1,
    RESP_NAK   = 3'h2,
    RESP_STALL = 3'h3,
    RESP_DATA  = 3'h4
  } udsec_resp_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } udsec_bus_s;

  typedef struct packed {
    logic       setup_req;
    logic       setup_pkt;
    logic       sof;
    logic       cfg_set;
    logic       cfg_value;
    logic       bus_reset;
    logic       bus_activity;
    logic       suspend_state;
    logic       line_idle;
    logic       remote_wake_en;
    logic       in_token;
    logic       in_ack;
    logic       out_token;
    logic       out_done;
    logic [3:0] rx_count;
    logic       rx_we;
    logic [2:0] rx_idx;
    logic [7:0] rx_byte;
    logic [2:0] tx_idx;
  } udsec_sie_s;

  typedef struct packed {
    logic [7:0]       ctrl;
    logic [7:0]       status;
    logic [7:0]       mask;
    logic [3:0]       csr;
    logic [3:0]       rx_size;
    logic [3:0]       tx_size;
    logic             rst_to_irq;
    logic             susp_mode;
    logic [CNT_W-1:0] resume_cnt;
    logic [CNT_W-1:0] idle_cnt;
    logic [7:0]       rdata;
    logic [7:0]       tx_byte;
    udsec_resp_e      resp;
    logic [7:0][7:0]  rx_buf;
    logic [7:0][7:0]  tx_buf;
  } udsec_state_s;

endpackage
`default_nettype wire

// ### core/udsec_ctrl.sv
// usb device status, interrupt mask and control endpoint logic
// Functional notes
// R1 - done enable gates both ep0 done flags
// R2 - resume write works only suspended with wakeup
// R3 - resume held over 3ms, reads zero
// R4 - config bit mirrors configuration one
// R5 - setup flag on error free request
// R6 - software decodes request from ep0 buffer
// R7 - frame start flag on sof packet
// R8 - config change flag on accepted configuration
// R9 - bus reset flag: reset or irq
// R10 - wakeup flag on activity while suspended
// R11 - suspend flag on suspend or idle
// R12 - software gates clock before stop mode
// R13 - forced stall until next setup
// R14 - masks enable irq per status flag
// R15 - bus reset irq only with irq select
// R16 - rx size holds last out count
// R17 - software writes tx size, write only
// R18 - armed bit, cleared by hardware, nak
// R19 - tx done flag forces in nak
// R20 - rx full until software clears, nak
// R21 - rx done on out or setup
// R22 - flags clear on write zero only
// R23 - module enable low resets the block; status mask enables, tx size, irq select and ep0 buffers keep their values
// R24 - clock gate before module enable
// R25 - single irq is or of enabled flags
// R26 - hardware set beats software clear
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module udsec_ctrl
  import udsec_pkg::*;
#(
  parameter logic [CNT_W-1:0] RESUME_LEN = CNT_W'(RESUME_CYCLES),
  parameter logic [CNT_W-1:0] IDLE_LEN   = CNT_W'(IDLE_CYCLES)
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire udsec_bus_s  bus,
  output logic [7:0]       rdata,
  input  wire udsec_sie_s  sie,
  output udsec_resp_e      ep0_resp,
  output logic [7:0]       tx_byte,
  output logic [3:0]       tx_size,
  output logic             resume_k,
  output logic             suspended,
  output logic             usb_clock_gate,
  output logic             mcu_reset_req,
  output logic             irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  udsec_state_s st;
  udsec_state_s next_st;

  logic       enabled;
  logic       wr_ctrl;
  logic       wr_status;
  logic       wr_mask;
  logic       wr_csr;
  logic       wr_size;
  logic       wr_config;
  logic       wr_buf;
  logic       idle_hit;
  logic [7:0] st_set;
  logic [3:0] csr_set;

  assign enabled   = st.ctrl[CTRL_ENABLE];
  assign wr_ctrl   = bus.wr && (bus.addr == ADDR_CTRL);
  assign wr_status = bus.wr && (bus.addr == ADDR_STATUS);
  assign wr_mask   = bus.wr && (bus.addr == ADDR_MASK);
  assign wr_csr    = bus.wr && (bus.addr == ADDR_EP0CSR);
  assign wr_size   = bus.wr && (bus.addr == ADDR_EP0SIZE);
  assign wr_config = bus.wr && (bus.addr == ADDR_CONFIG);
  assign wr_buf    = bus.wr && bus.addr[ADDR_BUF_BIT];
  assign idle_hit  = sie.line_idle && !st.susp_mode
                     && (st.idle_cnt == IDLE_LEN - 1'b1);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st      = st;
    next_st.resp = RESP_NONE;
    st_set       = '0;
    csr_set      = '0;

    // bus events
    // R5 setup request flag
    st_set[ST_SETUP]   = sie.setup_req;
    // R7 frame start flag
    st_set[ST_SOF]     = sie.sof;
    // R8 config change flag
    st_set[ST_CFG_CHG] = sie.cfg_set;
    // R9 bus reset flag
    st_set[ST_BUS_RST] = sie.bus_reset;
    // R10 wakeup flag
    st_set[ST_WAKEUP]  = sie.bus_activity && st.susp_mode
                         && (st.resume_cnt == '0);
    // R11 suspend flag
    st_set[ST_SUSPEND] = sie.suspend_state || idle_hit;

    // idle timer
    if (sie.line_idle && !st.susp_mode && !idle_hit) begin
      next_st.idle_cnt = st.idle_cnt + 1'b1;
    end else begin
      next_st.idle_cnt = '0;
    end

    // register writes
    if (wr_ctrl) begin
      next_st.ctrl = bus.wdata & CTRL_RW_BITS;
    end
    if (wr_mask) begin
      next_st.mask = (bus.wdata & MSK_RW_BITS)
                     | (st.mask & ~MSK_RW_BITS);
      // R13 stall set by one only
      if (bus.wdata[MSK_STALL]) begin
        next_st.mask[MSK_STALL] = 1'b1;
      end
    end
    if (wr_size) begin
      // R17 tx size write only
      next_st.tx_size = bus.wdata[SIZE_TX_LSB +: 4];
    end
    if (wr_config) begin
      next_st.rst_to_irq = bus.wdata[CFG_RST_TO_IRQ];
    end
    if (wr_buf) begin
      next_st.tx_buf[bus.addr[2:0]] = bus.wdata;
    end
    // R22 write zero clears flags
    if (wr_status) begin
      next_st.status = st.status & (bus.wdata | ~ST_FLAG_BITS);
    end
    if (wr_csr) begin
      next_st.csr[CSR_TX_DONE] = st.csr[CSR_TX_DONE]
                                 & bus.wdata[CSR_TX_DONE];
      next_st.csr[CSR_RX_FULL] = st.csr[CSR_RX_FULL]
                                 & bus.wdata[CSR_RX_FULL];
      next_st.csr[CSR_RX_DONE] = st.csr[CSR_RX_DONE]
                                 & bus.wdata[CSR_RX_DONE];
      // R18 software arms or disarms
      next_st.csr[CSR_TX_ARMED] = bus.wdata[CSR_TX_ARMED];
    end

    // R26 hardware set wins over clear
    next_st.status = next_st.status | st_set;

    // R4 single configuration
    if (sie.cfg_set) begin
      next_st.status[ST_CONFIG] = sie.cfg_value;
    end
    if (sie.bus_reset) begin
      next_st.status[ST_CONFIG] = 1'b0;
      next_st.susp_mode         = 1'b0;
    end

    // suspend and wakeup
    if (st_set[ST_WAKEUP]) begin
      next_st.susp_mode = 1'b0;
    end
    // R11 flag enters suspend mode
    if (st_set[ST_SUSPEND]) begin
      next_st.susp_mode = 1'b1;
    end

    // R2 remote wakeup request
    if (wr_ctrl && bus.wdata[CTRL_RESUME] && st.susp_mode
        && sie.remote_wake_en && (st.resume_cnt == '0)) begin
      // R3 long forced resume
      next_st.resume_cnt = RESUME_LEN;
    end else if (st.resume_cnt != '0) begin
      next_st.resume_cnt = st.resume_cnt - 1'b1;
      if (st.resume_cnt == 1'b1) begin
        next_st.susp_mode = 1'b0;
      end
    end

    // control endpoint handshake
    if (sie.in_token) begin
      // R13 stall on in token
      if (st.mask[MSK_STALL]) begin
        next_st.resp = RESP_STALL;
      // R19 done forces nak
      end else if (!st.csr[CSR_TX_ARMED] || st.csr[CSR_TX_DONE]) begin
        next_st.resp = RESP_NAK;
      end else begin
        next_st.resp = RESP_DATA;
      end
    end
    if (sie.out_token) begin
      if (st.mask[MSK_STALL]) begin
        next_st.resp = RESP_STALL;
      // R20 full buffer naks
      end else if (st.csr[CSR_RX_FULL] || st.csr[CSR_RX_DONE]) begin
        next_st.resp = RESP_NAK;
      end else begin
        next_st.resp = RESP_ACK;
      end
    end
    if (sie.in_ack) begin
      // R18 hardware disarms
      next_st.csr[CSR_TX_ARMED] = 1'b0;
      csr_set[CSR_TX_DONE]      = 1'b1;
    end
    if (sie.out_done) begin
      // R16 latch received count
      next_st.rx_size      = sie.rx_count;
      csr_set[CSR_RX_FULL] = 1'b1;
      csr_set[CSR_RX_DONE] = 1'b1;
    end
    if (sie.setup_pkt) begin
      // R21 setup also completes out
      next_st.rx_size           = sie.rx_count;
      csr_set[CSR_RX_DONE]      = 1'b1;
      next_st.csr[CSR_TX_ARMED] = 1'b0;
      // R13 stall ends at setup
      next_st.mask[MSK_STALL]   = 1'b0;
    end
    next_st.csr = next_st.csr | csr_set;
    if (sie.rx_we) begin
      next_st.rx_buf[sie.rx_idx] = sie.rx_byte;
    end
    next_st.tx_byte = st.tx_buf[sie.tx_idx];

    // R23 disabled module clears status, csr, rx size, stall, suspend and timers
    if (!enabled) begin
      next_st.status     = '0;
      next_st.csr        = '0;
      next_st.rx_size    = '0;
      next_st.susp_mode  = 1'b0;
      next_st.resume_cnt = '0;
      next_st.idle_cnt   = '0;
      next_st.resp       = RESP_NONE;
      next_st.mask[MSK_STALL] = 1'b0;
    end
    if (wr_ctrl) begin
      next_st.ctrl = bus.wdata & CTRL_RW_BITS;
    end

    // read data, one cycle after the strobe
    next_st.rdata = '0;
    if (bus.rd) begin
      if (bus.addr[ADDR_BUF_BIT]) begin
        next_st.rdata = st.rx_buf[bus.addr[2:0]];
      end else begin
        case (bus.addr)
          // R3 resume bit reads zero
          ADDR_CTRL:    next_st.rdata = st.ctrl;
          ADDR_STATUS:  next_st.rdata = st.status;
          ADDR_MASK:    next_st.rdata = st.mask & MSK_RW_BITS;
          ADDR_EP0CSR:  next_st.rdata = {4'h0, st.csr};
          ADDR_EP0SIZE: next_st.rdata = {4'h0, st.rx_size};
          ADDR_CONFIG:  next_st.rdata = {7'h00, st.rst_to_irq};
          default:      next_st.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata          = st.rdata;
  assign ep0_resp       = st.resp;
  assign tx_byte        = st.tx_byte;
  assign tx_size        = st.tx_size;
  assign resume_k       = (st.resume_cnt != '0);
  assign suspended      = st.susp_mode;
  assign usb_clock_gate = st.ctrl[CTRL_CLK_GATE];
  // R9 reset when irq not selected
  assign mcu_reset_req  = st.status[ST_BUS_RST] && !st.rst_to_irq;

  // R25 one interrupt line
  always_comb begin
    irq = 1'b0;
    // R14 status masks
    if (|(st.status & st.mask & ST_FLAG_BITS & ~(8'h01 << ST_BUS_RST))) begin
      irq = 1'b1;
    end
    // R15 bus reset irq
    if (st.status[ST_BUS_RST] && st.mask[ST_BUS_RST] && st.rst_to_irq) begin
      irq = 1'b1;
    end
    // R1 one enable for both ep0 flags
    if (st.ctrl[CTRL_DONE_IE]
        && (st.csr[CSR_TX_DONE] || st.csr[CSR_RX_DONE])) begin
      irq = 1'b1;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [CNT_W-1:0] k_len;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      k_len <= '0;
    end else if (resume_k) begin
      k_len <= k_len + 1'b1;
    end else begin
      k_len <= '0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_in_live;
    sie.in_token && enabled && !sie.out_token;
  endsequence

  sequence s_out_live;
    sie.out_token && enabled && !sie.in_token;
  endsequence

  property p_in_stall;
    s_in_live ##0 st.mask[MSK_STALL] |=> ep0_resp == RESP_STALL;
  endproperty
  a_in_stall: assert property (p_in_stall) // R13
    else $error("in token not stalled");

  property p_in_unarmed;
    s_in_live ##0 (!st.mask[MSK_STALL] && !st.csr[CSR_TX_ARMED])
      |=> ep0_resp == RESP_NAK;
  endproperty
  a_in_unarmed: assert property (p_in_unarmed) // R18
    else $error("unarmed in token not naked");

  property p_in_done;
    s_in_live ##0 (!st.mask[MSK_STALL] && st.csr[CSR_TX_DONE])
      |=> ep0_resp == RESP_NAK;
  endproperty
  a_in_done: assert property (p_in_done) // R19
    else $error("in token after done not naked");

  property p_out_full;
    s_out_live ##0 (!st.mask[MSK_STALL] && st.csr[CSR_RX_FULL])
      |=> ep0_resp == RESP_NAK;
  endproperty
  a_out_full: assert property (p_out_full) // R20
    else $error("out token with full buffer not naked");

  property p_out_done_sets;
    enabled && sie.out_done |=> st.csr[CSR_RX_DONE]
      && st.csr[CSR_RX_FULL] && st.rx_size == $past(sie.rx_count);
  endproperty
  a_out_done_sets: assert property (p_out_done_sets) // R21
    else $error("out completion not recorded");

  property p_sof_wins;
    enabled && sie.sof && wr_status && !wr_ctrl |=> st.status[ST_SOF];
  endproperty
  a_sof_wins: assert property (p_sof_wins) // R26
    else $error("frame start lost to a clear");

  property p_sof_irq;
    st.status[ST_SOF] && st.mask[ST_SOF] |-> irq;
  endproperty
  a_sof_irq: assert property (p_sof_irq) // R14
    else $error("enabled frame start gives no irq");

  property p_rst_path;
    enabled && sie.bus_reset && !st.rst_to_irq && !wr_config
      |=> mcu_reset_req ##0 !(irq && !st.mask[ST_BUS_RST]
      && st.status[ST_BUS_RST] && (st.status & st.mask) == '0);
  endproperty
  a_rst_path: assert property (p_rst_path) // R9
    else $error("bus reset did not request mcu reset");

  property p_resume_len;
    $fell(resume_k) |-> k_len >= RESUME_LEN;
  endproperty
  a_resume_len: assert property (p_resume_len) // R3
    else $error("forced resume too short");

  property p_resume_gate;
    wr_ctrl && bus.wdata[CTRL_RESUME] && !st.susp_mode && !resume_k
      |=> !resume_k;
  endproperty
  a_resume_gate: assert property (p_resume_gate) // R2
    else $error("resume driven while not suspended");

  property p_suspend_mode;
    enabled && sie.suspend_state && !wr_ctrl
      |=> st.status[ST_SUSPEND] && st.susp_mode;
  endproperty
  a_suspend_mode: assert property (p_suspend_mode) // R11
    else $error("suspend flag did not enter suspend mode");

endmodule
`default_nettype wire

// ### dv/udsec_host_model.sv
// bus side engine model that drives the block's usb event link
`timescale 1ns/1ns
`default_nettype none
module udsec_host_model
  import udsec_pkg::*;
(
  input  wire logic      ref_clk,
  output var udsec_sie_s sie
);
  initial sie = '0;
  // ****************************************************************
  // events and levels
  // ****************************************************************
  // only clean requests and valid resets are signalled
  task automatic pulse(input int k);
    @(posedge ref_clk);
    case (k)
      0: sie.setup_req <= 1'b1;
      1: sie.sof <= 1'b1;
      2: sie.cfg_set <= 1'b1;
      3: sie.bus_reset <= 1'b1;
      4: sie.setup_pkt <= 1'b1;
      5: sie.suspend_state <= 1'b1;
      6: sie.in_token <= 1'b1;
      7: sie.in_ack <= 1'b1;
      default: sie.out_token <= 1'b1;
    endcase
    @(posedge ref_clk);
    {sie.setup_req, sie.sof, sie.cfg_set, sie.bus_reset} <= '0;
    {sie.setup_pkt, sie.suspend_state, sie.in_token} <= '0;
    {sie.in_ack, sie.out_token} <= '0;
  endtask
  task automatic lvl(input int k, input logic v);
    @(posedge ref_clk);
    case (k)
      0: sie.line_idle <= v;
      1: sie.bus_activity <= v;
      2: sie.remote_wake_en <= v;
      default: sie.cfg_value <= v;
    endcase
  endtask
  task automatic set_tx_idx(input logic [2:0] i);
    @(posedge ref_clk);
    sie.tx_idx <= i;
  endtask
  // ****************************************************************
  // out packet into the receive buffer
  // ****************************************************************
  task automatic rx_fill(input logic [3:0] n);
    for (int i = 0; i < int'(n); i++) begin
      @(posedge ref_clk);
      sie.rx_we <= 1'b1;
      sie.rx_idx <= 3'(i);
      sie.rx_byte <= 8'(8'h10 + i);
    end
    @(posedge ref_clk);
    sie.rx_we <= 1'b0;
    // released data line no longer shows the last byte
    sie.rx_byte <= ~sie.rx_byte;
    sie.out_done <= 1'b1;
    sie.rx_count <= n;
    @(posedge ref_clk);
    sie.out_done <= 1'b0;
    sie.rx_count <= ~n;
  endtask
endmodule
`default_nettype wire

// ### dv/usb_device_status_ep0_control_tb.sv
// self-checking bench for the usb status and control endpoint block
`timescale 1ns/1ns
`default_nettype none
module usb_device_status_ep0_control_tb;
  import udsec_pkg::*;
  localparam logic [CNT_W-1:0] RES_LEN = 18'h14;
  localparam logic [CNT_W-1:0] IDL_LEN = 18'h1e;
  logic        ref_clk;
  logic        rst;
  udsec_bus_s  bus;
  logic [7:0]  rdata;
  udsec_sie_s  sie;
  udsec_resp_e resp;
  logic [7:0]  tx_byte;
  logic [3:0]  tx_size;
  logic        resume_k;
  logic        suspended;
  logic        clk_gate;
  logic        mcu_rst;
  logic        irq;
  int          err_count;
  int          n_compared;

  udsec_ctrl #(.RESUME_LEN(RES_LEN), .IDLE_LEN(IDL_LEN)) uut (
    .ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata), .sie(sie),
    .ep0_resp(resp), .tx_byte(tx_byte), .tx_size(tx_size),
    .resume_k(resume_k), .suspended(suspended),
    .usb_clock_gate(clk_gate), .mcu_reset_req(mcu_rst), .irq(irq));
  udsec_host_model host (.ref_clk(ref_clk), .sie(sie));

  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask
  task automatic tok(input int k, input udsec_resp_e exp);
    host.pulse(k);
    #1 check(8'(resp), 8'(exp));
  endtask
  task automatic wait_bit(ref logic s, input int n);
    for (int i = 0; i < n && s !== 1'b1; i++) @(posedge ref_clk) #1;
    if (s !== 1'b1) begin
      err_count++;
      end_of_test();
    end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    #1 check({resume_k, suspended, clk_gate, mcu_rst, irq, resp}, 8'h00);
    rchk(ADDR_CTRL, 8'h00);
    rchk(ADDR_STATUS, 8'h00);
    rchk(ADDR_MASK, 8'h00);
    rchk(ADDR_EP0CSR, 8'h00);
    wr(4'h7, 8'hff);
    rchk(4'h6, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_flags();
    logic [7:0] b;
    wr(ADDR_CTRL, 8'h02);
    wr(ADDR_CTRL, 8'h03);
    check({7'h0, clk_gate}, 8'h01);
    host.lvl(3, 1'b1);
    for (int k = 0; k < 3; k++) begin
      b = 8'(8'h02 << k);
      host.pulse(k);
      rchk(ADDR_STATUS, b | ((k == 2) ? 8'h01 : 8'h00));
      check({7'h0, irq}, 8'h00);
      wr(ADDR_MASK, b);
      check({7'h0, irq}, 8'h01);
      wr(ADDR_STATUS, ~b);
      rchk(ADDR_STATUS, (k == 2) ? 8'h01 : 8'h00);
      check({7'h0, irq}, 8'h00);
      wr(ADDR_MASK, 8'h00);
    end
    // configuration zero clears the config bit
    host.lvl(3, 1'b0);
    host.pulse(2);
    rchk(ADDR_STATUS, 8'h08);
    wr(ADDR_STATUS, 8'h00);
    fork
      host.pulse(1);
      wr(ADDR_STATUS, 8'h00);
    join
    rchk(ADDR_STATUS, 8'h04);
    host.pulse(3);
    #1 check({7'h0, mcu_rst}, 8'h01);
    rchk(ADDR_STATUS, 8'h14);
    wr(ADDR_MASK, 8'h10);
    check({7'h0, irq}, 8'h00);
    wr(ADDR_CONFIG, 8'h01);
    check({6'h0, mcu_rst, irq}, 8'h01);
    wr(ADDR_CTRL, 8'h00);
    rchk(ADDR_STATUS, 8'h00);
    wr(ADDR_MASK, 8'h00);
    $display("test flags done");
  endtask
  task automatic t_in();
    wr(ADDR_CTRL, 8'h0b);
    wr(4'ha, 8'ha5);
    wr(ADDR_EP0SIZE, 8'h30);
    check({4'h0, tx_size}, 8'h03);
    host.set_tx_idx(3'h2);
    tok(6, RESP_NAK);
    wr(ADDR_EP0CSR, 8'h01);
    rchk(ADDR_EP0CSR, 8'h01);
    tok(6, RESP_DATA);
    check(tx_byte, 8'ha5);
    wr(4'hb, 8'h5a);
    host.set_tx_idx(3'h3);
    @(posedge ref_clk) #1 check(tx_byte, 8'h5a);
    host.pulse(7);
    rchk(ADDR_EP0CSR, 8'h02);
    check({7'h0, irq}, 8'h01);
    wr(ADDR_EP0CSR, 8'h03);
    rchk(ADDR_EP0CSR, 8'h03);
    tok(6, RESP_NAK);
    wr(ADDR_EP0CSR, 8'h00);
    rchk(ADDR_EP0CSR, 8'h00);
    check({7'h0, irq}, 8'h00);
    $display("test in done");
  endtask
  task automatic t_out();
    tok(8, RESP_ACK);
    host.rx_fill(4'h8);
    rchk(ADDR_EP0CSR, 8'h0c);
    check({7'h0, irq}, 8'h01);
    rchk(ADDR_EP0SIZE, 8'h08);
    for (int i = 0; i < 8; i++) rchk(4'(8 + i), 8'(8'h10 + i));
    tok(8, RESP_NAK);
    wr(ADDR_EP0CSR, 8'h04);
    rchk(ADDR_EP0CSR, 8'h04);
    tok(8, RESP_NAK);
    wr(ADDR_EP0CSR, 8'h00);
    tok(8, RESP_ACK);
    $display("test out done");
  endtask
  task automatic t_stall();
    wr(ADDR_MASK, 8'h01);
    rchk(ADDR_MASK, 8'h00);
    tok(6, RESP_STALL);
    tok(8, RESP_STALL);
    wr(ADDR_MASK, 8'h00);
    tok(6, RESP_STALL);
    wr(ADDR_EP0CSR, 8'h01);
    host.pulse(4);
    rchk(ADDR_EP0CSR, 8'h08);
    tok(8, RESP_NAK);
    tok(6, RESP_NAK);
    wr(ADDR_EP0CSR, 8'h00);
    $display("test stall done");
  endtask
  task automatic t_susp();
    int n;
    host.lvl(2, 1'b1);
    wr(ADDR_CTRL, 8'h05);
    check({7'h0, resume_k}, 8'h00);
    host.lvl(0, 1'b1);
    repeat (15) @(posedge ref_clk);
    #1 check({7'h0, suspended}, 8'h00);
    wait_bit(suspended, 40);
    rchk(ADDR_STATUS, 8'h40);
    // clock gate left off while suspended
    check({7'h0, clk_gate}, 8'h00);
    host.lvl(2, 1'b0);
    wr(ADDR_CTRL, 8'h05);
    check({7'h0, resume_k}, 8'h00);
    host.lvl(2, 1'b1);
    host.lvl(0, 1'b0);
    wr(ADDR_CTRL, 8'h05);
    wait_bit(resume_k, 3);
    n = 0;
    while (resume_k === 1'b1 && n < 100) begin
      n++;
      @(posedge ref_clk) #1;
    end
    check(8'(n), 8'h14);
    check({7'h0, suspended}, 8'h00);
    rchk(ADDR_CTRL, 8'h01);
    wr(ADDR_STATUS, 8'h00);
    host.pulse(5);
    @(posedge ref_clk) #1 check({7'h0, suspended}, 8'h01);
    host.lvl(1, 1'b1);
    host.lvl(1, 1'b0);
    rchk(ADDR_STATUS, 8'h60);
    check({7'h0, suspended}, 8'h00);
    wr(ADDR_MASK, 8'h20);
    check({7'h0, irq}, 8'h01);
    $display("test suspend done");
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    err_count = 0;
    n_compared = 0;
    rst = 1'b1;
    bus = '0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_flags();
    t_in();
    t_out();
    t_stall();
    t_susp();
    end_of_test();
  end
endmodule
`default_nettype wire
